// *** hdl/ofe_pkg.sv ***
package ofe_pkg;

  // ==========================================================
  // widths
  localparam int unsigned OFE_DATA_W   = 8;
  localparam int unsigned OFE_STEP_W   = 8;
  localparam int unsigned OFE_SEL_W    = 5;
  localparam int unsigned OFE_ADDR_W   = OFE_STEP_W + OFE_SEL_W;
  localparam int unsigned OFE_ROM_W    = 8;
  localparam int unsigned OFE_DAC_W    = 12;

  // ==========================================================
  // frontend_control field positions
  localparam int unsigned OFE_FC_DIAGNOSTIC_SOURCE_SEL_BIT     = 0;
  localparam int unsigned OFE_FC_RUNCAL_BIT   = 1;
  localparam int unsigned OFE_FC_IR_GAIN_LSB  = 2;
  localparam int unsigned OFE_FC_RED_GAIN_LSB = 4;
  localparam int unsigned OFE_FC_SH_BIT       = 6;
  localparam int unsigned OFE_FC_REMUX_BIT    = 7;
  // program select = frontend_control[5:1]
  localparam int unsigned OFE_FC_SEL_LSB      = 1;

  // ==========================================================
  // dac_high_gain_select field positions
  localparam int unsigned OFE_DH_DAC_LSB      = 0;
  localparam int unsigned OFE_DH_DAC_W        = 4;
  localparam int unsigned OFE_DH_AC_GAIN_LSB  = 4;
  localparam int unsigned OFE_DH_DC_GAIN_LSB  = 6;

  // ==========================================================
  // reset values
  localparam logic [7:0] OFE_CTRL_RESET = 8'h00;
  localparam logic [7:0] OFE_STEP_RESET = 8'h00;

  // ==========================================================
  // sequencer timing
  localparam int unsigned OFE_SEQ_DIV      = 22;
  localparam int unsigned OFE_SEQ_HIGH_CNT = OFE_SEQ_DIV / 2;
  localparam int unsigned OFE_SHORT_BIT    = 5;

  // ==========================================================
  // program word, bit 0 = red drive
  typedef struct packed {
    logic [1:0] gain_sw;
    logic [3:0] demod_sw;
    logic       ir_drive;
    logic       red_drive;
  } ofe_seq_word_s;

endpackage : ofe_pkg

// *** hdl/ofe_seq_clkdiv.sv ***
`timescale 1ns/1ps
`default_nettype none

module ofe_seq_clkdiv
  import ofe_pkg::*;
#(
  parameter int unsigned DIV = OFE_SEQ_DIV
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic seq_clk,
  output var  logic rise_tick,
  output var  logic fall_tick
);

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          clk_q;

  // ==========================================================
  // divide counter
  assign cnt_d     = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
  // ticks mark the cycle before the level flips
  assign rise_tick = (cnt_q == LAST);
  assign fall_tick = (cnt_q == HALF);
  assign seq_clk   = clk_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (rise_tick) begin
        clk_q <= 1'b1;
      end else if (fall_tick) begin
        clk_q <= 1'b0;
      end
    end
  end

endmodule : ofe_seq_clkdiv

`default_nettype wire

// *** hdl/ofe_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

module ofe_sequencer
  import ofe_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] cpu_data,
  input  wire logic       frontend_ctrl_strobe,
  input  wire logic       dac_low_strobe,
  input  wire logic       dac_high_gain_strobe,
  input  wire logic       comp_status_rd,
  input  wire logic       interference_n_status_rd,
  input  wire logic       comparator_out_n,
  input  wire logic       interference_n,
  output var  logic       status_read_bit,
  output var  logic       diagnostic_source_sel,
  output var  logic       run_cal_sel,
  output var  logic       ir_gain_b0,
  output var  logic       ir_gain_b1,
  output var  logic       red_gain_b0,
  output var  logic       red_gain_b1,
  output var  logic       sample_hold_ctrl,
  output var  logic       channel_remux_sel,
  output var  logic [11:0] dac_code,
  output var  logic       ac_gain_b0,
  output var  logic       ac_gain_b1,
  output var  logic       dc_gain_b0,
  output var  logic       dc_gain_b1,
  output var  logic       sequencer_clk,
  output var  logic       red_led_drive,
  output var  logic       infrared_led_drive,
  output var  logic       demod_sw0,
  output var  logic       demod_sw1,
  output var  logic       demod_sw2,
  output var  logic       demod_sw3,
  output var  logic       preamp_gain_sw0,
  output var  logic       preamp_gain_sw1
);

  localparam int unsigned ROM_DEPTH = 1 << OFE_ADDR_W;

  logic [7:0]            fc_q;
  logic [7:0]            dl_q;
  logic [7:0]            dh_q;
  logic [OFE_STEP_W-1:0] step_q;
  logic [OFE_STEP_W-1:0] step_d;
  logic                  stat_q;
  ofe_seq_word_s         word_q;
  ofe_seq_word_s         rom_word;
  logic [OFE_SEL_W-1:0]  prog_sel;
  logic [OFE_ADDR_W-1:0] rom_addr;
  logic                  short_clr;
  logic                  rise_tick;
  logic                  fall_tick;
  logic [OFE_ROM_W-1:0]  rom [ROM_DEPTH];

  // ==========================================================
  // control registers
  // only local cpu strobes exist as write paths
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fc_q <= OFE_CTRL_RESET;
      dl_q <= OFE_CTRL_RESET;
      dh_q <= OFE_CTRL_RESET;
    end else begin
      if (frontend_ctrl_strobe) fc_q <= cpu_data;
      if (dac_low_strobe) dl_q <= cpu_data;
      if (dac_high_gain_strobe) dh_q <= cpu_data;
    end
  end

  assign diagnostic_source_sel = fc_q[OFE_FC_DIAGNOSTIC_SOURCE_SEL_BIT];
  assign run_cal_sel           = fc_q[OFE_FC_RUNCAL_BIT];
  assign ir_gain_b0            = fc_q[OFE_FC_IR_GAIN_LSB];
  assign ir_gain_b1            = fc_q[OFE_FC_IR_GAIN_LSB+1];
  assign red_gain_b0           = fc_q[OFE_FC_RED_GAIN_LSB];
  assign red_gain_b1           = fc_q[OFE_FC_RED_GAIN_LSB+1];
  // track/hold level goes straight to the s/h stage
  assign sample_hold_ctrl      = fc_q[OFE_FC_SH_BIT];
  // 1 steers one filtered channel, 0 the other
  assign channel_remux_sel     = fc_q[OFE_FC_REMUX_BIT];
  // lsb in dl_q bit 0, msb in dh_q bit 3
  assign dac_code   = {dh_q[OFE_DH_DAC_LSB +: OFE_DH_DAC_W], dl_q};
  assign ac_gain_b0 = dh_q[OFE_DH_AC_GAIN_LSB];
  assign ac_gain_b1 = dh_q[OFE_DH_AC_GAIN_LSB+1];
  assign dc_gain_b0 = dh_q[OFE_DH_DC_GAIN_LSB];
  assign dc_gain_b1 = dh_q[OFE_DH_DC_GAIN_LSB+1];

  // ==========================================================
  // status read: cpu polls these during trial dac writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= 1'b0;
    end else if (comp_status_rd) begin
      stat_q <= comparator_out_n;
    end else if (interference_n_status_rd) begin
      stat_q <= interference_n;
    end
  end

  assign status_read_bit = stat_q;

  // ==========================================================
  // sequencer clock
  ofe_seq_clkdiv #(
    .DIV (OFE_SEQ_DIV)
  ) u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .seq_clk   (sequencer_clk),
    .rise_tick (rise_tick),
    .fall_tick (fall_tick)
  );

  // ==========================================================
  // step counter and program address
  assign prog_sel  = fc_q[OFE_FC_SEL_LSB +: OFE_SEL_W];
  assign rom_addr  = {prog_sel, step_q};
  // the clear lands on the next clk edge, ahead of the next fall tick, in place of the asynchronous counter clear it replaces
  assign short_clr = step_q[OFE_SHORT_BIT] & word_q.red_drive;
  // clears to 0 once red drive is latched with step bit 5 set, else wraps at 256, so the chosen program loops forever
  assign step_d    = short_clr ? OFE_STEP_RESET
                   : (fall_tick ? step_q + 8'h01 : step_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_q <= OFE_STEP_RESET;
    end else begin
      step_q <= step_d;
    end
  end

  // ==========================================================
  // program table
  // default image: red, dark, ir, dark in eight-step phases;
  // gain switches follow the led lit cal mode keeps leds off
  initial begin
    for (int i = 0; i < ROM_DEPTH; i++) begin
      logic [OFE_ADDR_W-1:0] a;
      ofe_seq_word_s         w;
      a          = OFE_ADDR_W'(i);
      w          = '0;
      w.demod_sw = 4'h1 << a[4:3];
      if (a[8]) begin
        w.red_drive = (a[4:3] == 2'h0);
        w.ir_drive  = (a[4:3] == 2'h2);
      end
      w.gain_sw = (a[4:3] == 2'h2) ? a[10:9] : a[12:11];
      rom[i]    = w;
    end
  end

  assign rom_word = ofe_seq_word_s'(rom[rom_addr]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_q <= '0;
    end else if (rise_tick) begin
      word_q <= rom_word;
    end
  end

  assign red_led_drive      = word_q.red_drive;
  assign infrared_led_drive = word_q.ir_drive;
  assign demod_sw0          = word_q.demod_sw[0];
  assign demod_sw1          = word_q.demod_sw[1];
  assign demod_sw2          = word_q.demod_sw[2];
  assign demod_sw3          = word_q.demod_sw[3];
  assign preamp_gain_sw0    = word_q.gain_sw[0];
  assign preamp_gain_sw1    = word_q.gain_sw[1];

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_fc_write;
    frontend_ctrl_strobe |=> fc_q == $past(cpu_data);
  endproperty
  a_fc_write: assert property (p_fc_write) else $error("reg0 write lost");

  property p_fc_hold;
    !frontend_ctrl_strobe |=> $stable(fc_q);
  endproperty
  a_fc_hold: assert property (p_fc_hold) else $error("reg0 changed unstrobed");

  property p_dac_code;
    dac_low_strobe && dac_high_gain_strobe |=>
      dac_code == {$past(cpu_data[3:0]), $past(cpu_data)};
  endproperty
  a_dac_code: assert property (p_dac_code) else $error("dac code mismatch");

  property p_gains;
    dac_high_gain_strobe |=> {ac_gain_b1, ac_gain_b0} == $past(cpu_data[5:4])
      && {dc_gain_b1, dc_gain_b0} == $past(cpu_data[7:6]);
  endproperty
  a_gains: assert property (p_gains) else $error("gain code mismatch");

  property p_step_adv;
    fall_tick && !short_clr |=> step_q == $past(step_q) + 8'h01;
  endproperty
  a_step_adv: assert property (p_step_adv) else $error("step did not advance");

  property p_short;
    step_q[OFE_SHORT_BIT] && red_led_drive |=> step_q == OFE_STEP_RESET;
  endproperty
  a_short: assert property (p_short) else $error("short clear missed");

  property p_latch;
    rise_tick |=> word_q == $past(rom[{prog_sel, step_q}]);
  endproperty
  a_latch: assert property (p_latch) else $error("table word not latched");

  property p_latch_only;
    !rise_tick |=> $stable(word_q);
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("outputs moved off edge");

  property p_div;
    rise_tick |-> ##22 rise_tick;
  endproperty
  a_div: assert property (p_div) else $error("divider period wrong");

  property p_stat;
    comp_status_rd |=> status_read_bit == $past(comparator_out_n);
  endproperty
  a_stat: assert property (p_stat) else $error("status bit wrong");

  property p_reset;
    @(posedge clk) disable iff (1'b0)
      !rst_n |=> fc_q == OFE_CTRL_RESET && step_q == OFE_STEP_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

  property p_cov_short;
    short_clr;
  endproperty
  c_cov_short: cover property (p_cov_short);

  property p_cov_red;
    rise_tick ##1 red_led_drive;
  endproperty
  c_cov_red: cover property (p_cov_red);

  property p_cov_read;
    interference_n_status_rd ##1 !status_read_bit;
  endproperty
  c_cov_read: cover property (p_cov_read);

endmodule : ofe_sequencer

`default_nettype wire

// *** tb/ofe_afe_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// analog back end: held signal against dac code
module ofe_afe_model
  import ofe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [11:0] level,
  input  wire logic        sample_hold_ctrl,
  input  wire logic [11:0] dac_code,
  output var  logic        comparator_out_n,
  output var  logic        interference_n
);
  logic [11:0] held_q;

  // ideal hold, no droop modelled
  always_ff @(posedge clk) begin
    if (!sample_hold_ctrl) begin
      held_q <= level;
    end
  end

  assign comparator_out_n = !(held_q >= dac_code);
  // saturation threshold is arbitrary
  assign interference_n = !(level[11:10] == 2'b11);
endmodule : ofe_afe_model

`default_nettype wire

// *** tb/oximeter_frontend_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module oximeter_frontend_sequencer_test import ofe_pkg::*;;
  logic clk = '0, rst_n = '0;
  logic [7:0] cpu_data = '0;
  logic frontend_ctrl_strobe = '0, dac_low_strobe = '0, dac_high_gain_strobe = '0;
  logic comp_status_rd = '0, interference_n_status_rd = '0;
  logic [11:0] level = '0, dac_code, lv, held;
  logic comparator_out_n, interference_n, status_read_bit, sequencer_clk;
  logic diagnostic_source_sel, run_cal_sel, ir_gain_b0, ir_gain_b1, red_gain_b0, red_gain_b1;
  logic sample_hold_ctrl, channel_remux_sel, ac_gain_b0, ac_gain_b1, dc_gain_b0, dc_gain_b1;
  logic red_led_drive, infrared_led_drive, demod_sw0, demod_sw1, demod_sw2, demod_sw3;
  logic preamp_gain_sw0, preamp_gain_sw1;
  logic [24:0] obs;
  logic [7:0]  seqv, pseq, r0, r1, r2;
  logic [8:0]  sv;
  logic        st, taken, chk, pclk, prst;
  logic [24:0] exp_q[$];
  int          num_errors = 0, n_compared = 0;

  assign obs = {channel_remux_sel, sample_hold_ctrl, red_gain_b1, red_gain_b0, ir_gain_b1, ir_gain_b0,
                run_cal_sel, diagnostic_source_sel, dac_code, dc_gain_b1, dc_gain_b0, ac_gain_b1,
                ac_gain_b0, status_read_bit};
  assign seqv = {preamp_gain_sw1, preamp_gain_sw0, demod_sw3, demod_sw2, demod_sw1, demod_sw0,
                 infrared_led_drive, red_led_drive};
  assign sv = {sequencer_clk, seqv};

  ofe_sequencer DUT (.clk, .rst_n, .cpu_data, .frontend_ctrl_strobe, .dac_low_strobe, .dac_high_gain_strobe,
    .comp_status_rd, .interference_n_status_rd, .comparator_out_n, .interference_n, .status_read_bit,
    .diagnostic_source_sel, .run_cal_sel, .ir_gain_b0, .ir_gain_b1, .red_gain_b0, .red_gain_b1,
    .sample_hold_ctrl, .channel_remux_sel, .dac_code, .ac_gain_b0, .ac_gain_b1, .dc_gain_b0, .dc_gain_b1,
    .sequencer_clk, .red_led_drive, .infrared_led_drive, .demod_sw0, .demod_sw1, .demod_sw2, .demod_sw3,
    .preamp_gain_sw0, .preamp_gain_sw1);
  ofe_afe_model afe (.clk, .level, .sample_hold_ctrl, .dac_code, .comparator_out_n, .interference_n);

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // driver: called just after a rising edge, returns at the taking edge
  task automatic op(input logic [2:0] s, input logic [1:0] rd, input logic [7:0] d);
    cpu_data <= d;
    {dac_high_gain_strobe, dac_low_strobe, frontend_ctrl_strobe} <= s;
    {interference_n_status_rd, comp_status_rd} <= rd;
    if (s[0]) r0 = d;
    if (s[1]) r1 = d;
    if (s[2]) r2 = d;
    // never mixed with a write: comparator would still see the old code
    if (rd[0]) st = !(held >= {r2[3:0], r1});
    else if (rd[1]) st = !(lv[11:10] == 2'b11);
    if (s != '0 || rd != '0) exp_q.push_back({r0, r2[3:0], r1, r2[7:4], st});
    @(posedge clk);
  endtask : op

  task automatic gap(input int b, output int n);
    logic p;
    n = 0;
    p = 1'b1;
    while (!(sv[b] && !p) && n < 3000) begin p = sv[b]; @(negedge clk); n++; end
    n = 0;
    do begin p = sv[b]; @(negedge clk); n++; end while (!(sv[b] && !p) && n < 3000);
  endtask : gap

  task automatic sar(input logic [11:0] v);
    logic [11:0] code;
    code = '0;
    lv = v;
    level <= v;
    op(3'b001, '0, '0);
    op(3'b001, '0, 8'h40);
    held = v;
    lv = ~v;
    level <= ~v;
    for (int b = 11; b >= 0; b--) begin
      code[b] = 1'b1;
      op(3'b010, '0, code[7:0]);
      op(3'b100, '0, {r2[7:4], code[11:8]});
      op('0, 2'b01, '0);
      if (st) code[b] = 1'b0;
    end
    // last trial bit may have been dropped after its write
    op(3'b010, '0, code[7:0]);
    op('0, '0, '0);
    check(dac_code, v, "conversion");
  endtask : sar

  // ==========================================================
  // monitor
  always @(posedge clk) begin
    taken = rst_n & (frontend_ctrl_strobe | dac_low_strobe | dac_high_gain_strobe | comp_status_rd
                     | interference_n_status_rd);
  end

  always @(negedge clk) begin
    if (taken) begin
      if (exp_q.size() == 0) check(1, 0, "queue empty");
      else check(obs, exp_q.pop_front(), "regs");
    end
    if (rst_n && prst && seqv !== pseq) begin
      check({pclk, sequencer_clk}, 2'b01, "latch edge");
      if (chk && red_led_drive) check(seqv[7:6], r0[5:4], "red gain");
      if (chk && infrared_led_drive) check(seqv[7:6], r0[3:2], "ir gain");
      // default image: red phase demod one-hot bit 0, ir phase bit 2
      if (chk && red_led_drive) check(seqv[5:2], 4'h1, "red demod");
      if (chk && infrared_led_drive) check(seqv[5:2], 4'h4, "ir demod");
    end
    {pclk, prst, pseq} = {sequencer_clk, rst_n, seqv};
  end

  // ==========================================================
  // tests
  initial begin
    int n;
    void'($urandom(32'hFF12));
    {r0, r1, r2, st, chk} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({obs, sv}, '0, "reset");
    $display("test reset done");
    @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      op(3'b001, '0, '0);
      lv = k ? 12'($urandom) | 12'hC00 : 12'($urandom) & 12'h3FF;
      level <= lv;
      held = lv;
      op('0, '0, '0);
      for (int i = 0; i < 40; i++) begin
        if ($urandom % 3 == 0) op('0, 2'($urandom % 3 + 1), '0);
        else op(3'($urandom % 7 + 1), '0, 8'($urandom));
      end
    end
    op('0, '0, '0);
    $display("test registers done");
    sar(12'($urandom));
    sar(12'hFFF);
    sar('0);
    $display("test conversion done");
    for (int g = 0; g < 2; g++) begin
      chk = 1'b0;
      op(3'b001, '0, g ? 8'h1E : 8'h26);
      op('0, '0, '0);
      chk = 1'b1;
      gap(8, n);
      check(n, OFE_SEQ_DIV, "seq clk period");
      n = 0;
      while (sequencer_clk && n < 50) begin @(negedge clk); n++; end
      check(n, OFE_SEQ_HIGH_CNT, "seq clk high");
      gap(0, n);
      // clear lands after step 32 is latched and before the next fall tick, so step 0 is never latched and the loop is 32 steps
      check(n, 32 * OFE_SEQ_DIV, "program period");
      @(posedge clk);
    end
    $display("test sequencer done");
    chk = 1'b0;
    op(3'b111, '0, 8'hFF);
    op('0, '0, '0);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    {r0, r1, r2, st} = '0;
    @(negedge clk);
    check({obs, sv}, '0, "mid reset");
    $display("test mid reset done");
    end_of_test();
  end

  // whole run needs about 2830 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule : oximeter_frontend_sequencer_test

`default_nettype wire
